// [rtl/pmd_cfg.svh]
// constants for the processor memory decode block
`ifndef PMD_CFG_SVH
`define PMD_CFG_SVH
`define PMD_ADDR_W 16
`define PMD_DATA_W 8
`define PMD_ROM_N 6
`define PMD_ROM_ADDR_W 12
`define PMD_SEL_LO 12
`define PMD_SEL_HI 14
`define PMD_MEM_BIT 15
`define PMD_ADAPTER_BIT 11
`define PMD_MAIN_RAM_W 10
`define PMD_KEEP_RAM_W 8
`define PMD_MAIN_RAM_CODE 3'h0
`define PMD_KEEP_RAM_CODE 3'h1
`define PMD_ADAPTER_CODE 3'h4
`define PMD_INPUT_CODE 3'h6
`define PMD_INPUT_GROUPS 8
`define PMD_BASE_MHZ_X10 38
`define PMD_SYS_MHZ 200
`define PMD_BASE_DIV ((`PMD_SYS_MHZ * 10) / (`PMD_BASE_MHZ_X10 * 2))
`define PMD_DIV_W 8
`define PMD_RESET_US 2
`define PMD_RESET_CYC (`PMD_RESET_US * `PMD_SYS_MHZ)
`define PMD_RESET_W 12
`endif

// [rtl/pmd_pkg.sv]
// types for the processor memory decode block
package pmd_pkg;
  typedef enum logic [1:0] {
    PMD_PH_FETCH,
    PMD_PH_EXEC
  } pmd_phase_e;
endpackage

// [rtl/pmd_clk_if.sv]
// phase enables shared between the clock generator and the decoder
`timescale 1ns/1ps
interface pmd_clk_if;
  logic base_en;
  logic half_en;
  logic ph1;
  logic ph2;
  modport gen (output base_en, output half_en, output ph1, output ph2);
  modport use_ (input base_en, input half_en, input ph1, input ph2);
endinterface

// [rtl/pmd_clkgen.sv]
// two-phase clock generator from the base oscillator rate
`timescale 1ns/1ps
`include "pmd_cfg.svh"
module pmd_clkgen (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // phase outputs
  pmd_clk_if.gen ck
);
  typedef struct packed {
    logic [`PMD_DIV_W-1:0] div;
    logic [2:0] quad;
    logic base_en;
    logic half_en;
    logic ph1;
    logic ph2;
  } pmd_gen_s;
  pmd_gen_s st, next_st;
  // ==========================================================
  // divider
  always_comb begin
    next_st = st;
    next_st.base_en = 1'b0;
    next_st.half_en = 1'b0;
    if (st.div == `PMD_DIV_W'(`PMD_BASE_DIV - 1)) begin // R9
      next_st.div = '0;
      next_st.base_en = 1'b1;
      next_st.quad = st.quad + 3'h1;
      next_st.half_en = st.quad[0];
      next_st.ph1 = !next_st.quad[2]; // R9
      next_st.ph2 = next_st.quad[2]; // R9
    end else begin
      next_st.div = st.div + `PMD_DIV_W'(1);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign ck.base_en = st.base_en;
  assign ck.half_en = st.half_en;
  assign ck.ph1 = st.ph1;
  assign ck.ph2 = st.ph2;
endmodule

// [rtl/pmd_top.sv]
// address decode, strobe gating, reset and phase logic around the processor
`timescale 1ns/1ps
`include "pmd_cfg.svh"
// Notes on behaviour
// R1: processor uses 16-bit address and 8-bit data buses for all transfers
// R2: low twelve address bits go in parallel to every rom
// R3: bits 12-14 enable at most one of six roms
// R4: rom buffer on only for bit 15 high, read, phase two high
// R5: bit 15 low selects ram; bits 12-14 pick the pair
// R6: on ram read both ram write lines stay high
// R7: main pair word address bits 0-9, keep-alive pair bits 0-7
// R8: read/write line high means read, low means write
// R9: base, half rate outputs and two quarter rate phases
// R10: processor held while reset low, restarts when it rises; code holds it while rst is high and for 400 cycles after rst falls
// R11: bits 0-2 with 12-15 pick one of eight input groups
// R12: adapter writes go out on port a or port b
// R13: phases alternate fetch and execute
// R14: ram writes only with write strobe low, address before data
// R15: adapter enabled only with bit 11 high and select low; bits 0-1 pick port
// R16: unfitted rom codes leave every rom disabled
module pmd_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // processor bus
  input wire logic [`PMD_ADDR_W-1:0] cpu_addr,
  input wire logic cpu_rd_wr,
  input wire logic [`PMD_DATA_W-1:0] cpu_data_out,
  input wire logic cpu_data_oe,
  output logic [`PMD_DATA_W-1:0] cpu_data_in,
  output logic cpu_reset_n,
  output logic cpu_fetch,
  // clock outputs
  output logic clk_base,
  output logic clk_half,
  output logic clk_ph1,
  output logic clk_ph2,
  // rom side
  input wire logic [`PMD_DATA_W-1:0] rom_data,
  output logic [`PMD_ROM_ADDR_W-1:0] rom_addr,
  output logic [`PMD_ROM_N-1:0] rom_en,
  output logic rom_buf_en,
  // ram side
  input wire logic [`PMD_DATA_W-1:0] ram_rdata,
  output logic [`PMD_MAIN_RAM_W-1:0] main_ram_addr,
  output logic [`PMD_KEEP_RAM_W-1:0] keep_ram_addr,
  output logic main_ram_sel,
  output logic keep_ram_sel,
  output logic main_ram_write_n,
  output logic keep_ram_rd_wr,
  output logic [`PMD_DATA_W-1:0] ram_wdata,
  output logic ram_wdata_oe,
  // instrument inputs, from pins
  input wire logic [`PMD_INPUT_GROUPS*`PMD_DATA_W-1:0] inst_inputs,
  // parallel output adapter
  input wire logic adapter_select_n,
  output logic [`PMD_DATA_W-1:0] parallel_output_adapter_a,
  output logic [`PMD_DATA_W-1:0] parallel_output_adapter_b,
  output logic adapter_strobe
);
  localparam int GW = `PMD_INPUT_GROUPS * `PMD_DATA_W;
  typedef struct packed {
    logic [GW-1:0] in_s1;
    logic [GW-1:0] in_s2;
    logic sel_s1;
    logic sel_s2;
    logic [`PMD_RESET_W-1:0] rst_cnt;
    logic cpu_reset_n;
    pmd_pkg::pmd_phase_e phase;
    logic [`PMD_DATA_W-1:0] data_in;
    logic [`PMD_ROM_ADDR_W-1:0] rom_addr;
    logic [`PMD_ROM_N-1:0] rom_en;
    logic rom_buf_en;
    logic [`PMD_MAIN_RAM_W-1:0] main_addr;
    logic [`PMD_KEEP_RAM_W-1:0] keep_addr;
    logic main_sel;
    logic keep_sel;
    logic main_wr_n;
    logic keep_rd_wr;
    logic [`PMD_DATA_W-1:0] wdata;
    logic wdata_oe;
    logic [`PMD_DATA_W-1:0] port_a;
    logic [`PMD_DATA_W-1:0] port_b;
    logic strobe;
    logic base;
    logic half;
    logic ph1;
    logic ph2;
    logic fetch;
    logic [`PMD_ADDR_W-1:0] addr_q;
  } pmd_top_s;
  pmd_top_s st, next_st;
  pmd_clk_if ck ();
  logic [2:0] code;
  logic mem_rom;
  logic is_read;
  logic adapter_on;
  logic adapter_hit;
  logic adapter_wr;
  logic addr_held;
  logic ph2_rise;
  pmd_clkgen u_clkgen (
    .clk_sys(clk_sys),
    .rst(rst),
    .ck(ck)
  );
  // ==========================================================
  // address decode
  assign code = cpu_addr[`PMD_SEL_HI:`PMD_SEL_LO];
  assign mem_rom = cpu_addr[`PMD_MEM_BIT];
  assign is_read = cpu_rd_wr; // R8
  assign adapter_hit = !mem_rom && (code == `PMD_ADAPTER_CODE) && cpu_addr[`PMD_ADAPTER_BIT]; // R15
  assign adapter_wr = !st.sel_s2 && !is_read; // R15
  assign adapter_on = adapter_hit && adapter_wr;
  assign addr_held = (cpu_addr == st.addr_q); // R14
  assign ph2_rise = ck.ph2 && !st.ph2;
  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.in_s1 = inst_inputs;
    next_st.in_s2 = st.in_s1;
    next_st.sel_s1 = adapter_select_n;
    next_st.sel_s2 = st.sel_s1;
    if (ck.base_en) begin
      next_st.base = !st.base; // R9
    end
    if (ck.half_en) begin
      next_st.half = !st.half; // R9
    end
    next_st.ph1 = ck.ph1;
    next_st.ph2 = ck.ph2;
    // power-on hold of processor reset
    if (st.rst_cnt != `PMD_RESET_W'(`PMD_RESET_CYC)) begin
      next_st.rst_cnt = st.rst_cnt + `PMD_RESET_W'(1);
      next_st.cpu_reset_n = 1'b0; // R10
    end else begin
      next_st.cpu_reset_n = 1'b1; // R10
    end
    if (!st.cpu_reset_n) begin
      next_st.phase = pmd_pkg::PMD_PH_FETCH;
    end else if (ck.base_en && ck.ph2 && st.ph1) begin
      case (st.phase) // R13
        pmd_pkg::PMD_PH_FETCH: next_st.phase = pmd_pkg::PMD_PH_EXEC;
        pmd_pkg::PMD_PH_EXEC: next_st.phase = pmd_pkg::PMD_PH_FETCH;
        default: next_st.phase = pmd_pkg::PMD_PH_FETCH;
      endcase
    end
    next_st.fetch = (next_st.phase == pmd_pkg::PMD_PH_FETCH); // R13
    next_st.addr_q = cpu_addr;
    next_st.rom_addr = cpu_addr[`PMD_ROM_ADDR_W-1:0]; // R2
    next_st.rom_en = '0;
    if (mem_rom && (code < 3'(`PMD_ROM_N))) begin // R16
      next_st.rom_en[code] = 1'b1; // R3
    end
    next_st.rom_buf_en = mem_rom && is_read && ck.ph2; // R4
    next_st.main_addr = cpu_addr[`PMD_MAIN_RAM_W-1:0]; // R7
    next_st.keep_addr = cpu_addr[`PMD_KEEP_RAM_W-1:0]; // R7
    next_st.main_sel = !mem_rom && (code == `PMD_MAIN_RAM_CODE); // R5
    next_st.keep_sel = !mem_rom && (code == `PMD_KEEP_RAM_CODE); // R5
    next_st.main_wr_n = !(next_st.main_sel && !is_read && ck.ph2 && cpu_data_oe && addr_held); // R6 R14
    next_st.keep_rd_wr = !(next_st.keep_sel && !is_read && ck.ph2 && cpu_data_oe && addr_held); // R6 R14
    next_st.wdata = cpu_data_out; // R1
    next_st.wdata_oe = !is_read && (next_st.main_sel || next_st.keep_sel);
    // read data onto the processor bus
    if (mem_rom) begin
      if (next_st.rom_buf_en && (st.rom_en != '0)) begin // R16
        next_st.data_in = rom_data;
      end else begin
        next_st.data_in = '0;
      end
    end else if (code == `PMD_INPUT_CODE) begin
      next_st.data_in = st.in_s2[cpu_addr[2:0]*`PMD_DATA_W +: `PMD_DATA_W]; // R11
    end else if (next_st.main_sel || next_st.keep_sel) begin
      next_st.data_in = ram_rdata;
    end else begin
      next_st.data_in = '0;
    end
    next_st.strobe = 1'b0;
    if (adapter_on && ph2_rise) begin
      next_st.strobe = 1'b1;
      if (cpu_addr[1:0] == 2'h0) begin // R12
        next_st.port_a = cpu_data_out;
      end else if (cpu_addr[1:0] == 2'h2) begin
        next_st.port_b = cpu_data_out;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
      st.sel_s1 <= 1'b1;
      st.sel_s2 <= 1'b1;
      st.main_wr_n <= 1'b1;
      st.keep_rd_wr <= 1'b1;
      st.fetch <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
  // ==========================================================
  // outputs
  assign cpu_data_in = st.data_in;
  assign cpu_reset_n = st.cpu_reset_n;
  assign cpu_fetch = st.fetch;
  assign clk_base = st.base;
  assign clk_half = st.half;
  assign clk_ph1 = st.ph1;
  assign clk_ph2 = st.ph2;
  assign rom_addr = st.rom_addr;
  assign rom_en = st.rom_en;
  assign rom_buf_en = st.rom_buf_en;
  assign main_ram_addr = st.main_addr;
  assign keep_ram_addr = st.keep_addr;
  assign main_ram_sel = st.main_sel;
  assign keep_ram_sel = st.keep_sel;
  assign main_ram_write_n = st.main_wr_n;
  assign keep_ram_rd_wr = st.keep_rd_wr;
  assign ram_wdata = st.wdata;
  assign ram_wdata_oe = st.wdata_oe;
  assign parallel_output_adapter_a = st.port_a;
  assign parallel_output_adapter_b = st.port_b;
  assign adapter_strobe = st.strobe;
endmodule

// [testbench/pmd_top_checker.sv]
// port assertions for the processor memory decode block
`timescale 1ns/1ps
module pmd_top_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // processor side
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_rd_wr,
  input wire logic cpu_reset_n,
  input wire logic adapter_strobe,
  // memory side
  input wire logic [11:0] rom_addr,
  input wire logic [5:0] rom_en,
  input wire logic rom_buf_en,
  input wire logic [9:0] main_ram_addr,
  input wire logic [7:0] keep_ram_addr,
  input wire logic main_ram_write_n,
  input wire logic keep_ram_rd_wr
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ==========
  // checks
  rom_addr_a: assert property (!$past(rst) |-> rom_addr == $past(cpu_addr[11:0]))
    else $error("rom addr");
  rom_sel_a: assert property (|rom_en |-> $past(cpu_addr[15]) && rom_en == 6'h01 << $past(cpu_addr[14:12]))
    else $error("rom sel");
  rom_none_a: assert property ($past(cpu_addr[15]) && $past(cpu_addr[14:12]) > 3'h5 |-> rom_en == 6'h00)
    else $error("rom none");
  rom_buf_a: assert property (rom_buf_en |-> $past(cpu_addr[15]) && $past(cpu_rd_wr))
    else $error("rom buf");
  ram_read_a: assert property ($past(cpu_rd_wr) |-> main_ram_write_n && keep_ram_rd_wr)
    else $error("ram read");
  ram_word_a: assert property (!$past(rst) |-> {main_ram_addr, keep_ram_addr} == $past({cpu_addr[9:0], cpu_addr[7:0]}))
    else $error("ram word");
  reset_hold_a: assert property ($fell(rst) |-> !cpu_reset_n [*8])
    else $error("reset hold");
  adapter_pulse_a: assert property (adapter_strobe |-> !$past(cpu_rd_wr) && $past(cpu_addr[11]) ##1 !adapter_strobe)
    else $error("adapter");
endmodule
bind pmd_top pmd_top_checker i_pmd_top_checker (.clk_sys, .rst, .cpu_addr, .cpu_rd_wr, .cpu_reset_n,
  .adapter_strobe, .rom_addr, .rom_en, .rom_buf_en, .main_ram_addr, .keep_ram_addr, .main_ram_write_n,
  .keep_ram_rd_wr);

// [testbench/pmd_mem_model.sv]
// rom and ram chips on the processor bus
`timescale 1ns/1ps
module pmd_mem_model (
  // clock
  input wire logic clk_sys,
  // rom side
  input wire logic [11:0] rom_addr,
  input wire logic [5:0] rom_en,
  output logic [7:0] rom_data,
  // ram side
  input wire logic [9:0] main_ram_addr,
  input wire logic [7:0] keep_ram_addr,
  input wire logic main_ram_sel,
  input wire logic keep_ram_sel,
  input wire logic main_ram_write_n,
  input wire logic keep_ram_rd_wr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_wdata_oe,
  output logic [7:0] ram_rdata
);
  logic [7:0] main_mem [1024];
  logic [7:0] keep_mem [256];
  logic [7:0] junk = 8'h00;
  // ==========
  // writes only while the strobe is low
  always @(posedge clk_sys) begin
    junk <= ~junk ^ 8'h5A;
    if (main_ram_sel && !main_ram_write_n && ram_wdata_oe) main_mem[main_ram_addr] <= ram_wdata;
    if (keep_ram_sel && !keep_ram_rd_wr && ram_wdata_oe) keep_mem[keep_ram_addr] <= ram_wdata;
  end
  assign rom_data = |rom_en ? rom_addr[7:0] ^ {2'h0, rom_en} : junk;
  assign ram_rdata = main_ram_sel ? main_mem[main_ram_addr] : keep_ram_sel ? keep_mem[keep_ram_addr] : junk;
endmodule

// [testbench/pmd_top_tb_top.sv]
// self-checking bench for the processor memory decode block
`timescale 1ns/1ps
`include "pmd_cfg.svh"
module pmd_top_tb_top;
  logic clk_sys = 0, rst = 1, cpu_rd_wr = 1, cpu_data_oe = 0, adapter_select_n = 1;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_data_out = 8'h00;
  logic [63:0] inst_inputs = 64'hF0E1D2C3B4A59687;
  logic [7:0] cpu_data_in, rom_data, ram_rdata, ram_wdata, parallel_output_adapter_a, parallel_output_adapter_b;
  logic [11:0] rom_addr;
  logic [9:0] main_ram_addr;
  logic [7:0] keep_ram_addr;
  logic [5:0] rom_en;
  logic cpu_reset_n, cpu_fetch, clk_base, clk_half, clk_ph1, clk_ph2, rom_buf_en, main_ram_sel, keep_ram_sel;
  logic main_ram_write_n, keep_ram_rd_wr, ram_wdata_oe, adapter_strobe;
  int n_mismatch = 0, checked = 0;
  always #2.5 clk_sys = ~clk_sys;
  pmd_top i_pmd_top (.clk_sys, .rst, .cpu_addr, .cpu_rd_wr, .cpu_data_out, .cpu_data_oe, .cpu_data_in,
    .cpu_reset_n, .cpu_fetch, .clk_base, .clk_half, .clk_ph1, .clk_ph2, .rom_data, .rom_addr, .rom_en,
    .rom_buf_en, .ram_rdata, .main_ram_addr, .keep_ram_addr, .main_ram_sel, .keep_ram_sel, .main_ram_write_n,
    .keep_ram_rd_wr, .ram_wdata, .ram_wdata_oe, .inst_inputs, .adapter_select_n, .parallel_output_adapter_a,
    .parallel_output_adapter_b, .adapter_strobe);
  pmd_mem_model i_pmd_mem_model (.clk_sys, .rom_addr, .rom_en, .rom_data, .main_ram_addr, .keep_ram_addr,
    .main_ram_sel, .keep_ram_sel, .main_ram_write_n, .keep_ram_rd_wr, .ram_wdata, .ram_wdata_oe, .ram_rdata);
  // ==========
  // shared tasks
  task automatic test_done();
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  // one access: address first, data once phase two is low, sampled three cycles into phase two
  task automatic acc(logic [15:0] a, logic w, logic [7:0] d);
    int i;
    {cpu_addr, cpu_rd_wr, cpu_data_oe} = {a, ~w, 1'b0};
    for (i = 0; i < 999 && (i == 0 || clk_ph2 !== 1'b0); i++) tick();
    {cpu_data_out, cpu_data_oe} = {d, w};
    while (i < 999 && clk_ph2 !== 1'b1) begin
      tick();
      i++;
    end
    if (i > 998) begin
      n_mismatch++;
      test_done();
    end else begin
      repeat (3) tick();
    end
  endtask
  // ==========
  // scenarios
  task automatic t_rom();
    for (int c = 0; c < 8; c++) begin
      acc(16'h80A5 | 16'(c << 12), 1'b0, 8'h00);
      chk("rom_en", rom_en, c < 6 ? 16'h0001 << c : 16'h0000);
      chk("rom_addr", rom_addr, 16'h00A5);
      chk("rom_buf", rom_buf_en, 16'h0001);
      chk("rom_data", cpu_data_in, c < 6 ? 16'h00A5 ^ (16'h0001 << c) : 16'h0000);
    end
  endtask
  task automatic t_ram();
    acc(16'h0123, 1'b1, 8'h5A);
    chk("main_write", {main_ram_sel, keep_ram_sel, ram_wdata_oe, main_ram_write_n, ram_wdata}, 16'h0A5A);
    acc(16'h1045, 1'b1, 8'hC3);
    chk("keep_write", {main_ram_sel, keep_ram_sel, ram_wdata_oe, keep_ram_rd_wr, ram_wdata}, 16'h06C3);
    acc(16'h0D23, 1'b0, 8'h00);
    chk("main_ram", cpu_data_in, 16'h005A);
    chk("ram_wr_lines", {main_ram_write_n, keep_ram_rd_wr, rom_buf_en}, 16'h0006);
    acc(16'h1345, 1'b0, 8'h00);
    chk("keep_ram", cpu_data_in, 16'h00C3);
  endtask
  task automatic t_inputs();
    for (int g = 0; g < 8; g++) begin
      acc(16'h6000 | 16'(g), 1'b0, 8'h00);
      chk("input_group", cpu_data_in, 16'(inst_inputs[8*g +: 8]));
    end
  endtask
  task automatic t_adapter();
    adapter_select_n = 0;
    acc(16'h4800, 1'b1, 8'h3C);
    acc(16'h4802, 1'b1, 8'h96);
    chk("port_a", parallel_output_adapter_a, 16'h003C);
    chk("port_b", parallel_output_adapter_b, 16'h0096);
    acc(16'h4000, 1'b1, 8'h11);
    adapter_select_n = 1;
    acc(16'h4800, 1'b1, 8'h22);
    chk("port_a_held", parallel_output_adapter_a, 16'h003C);
  endtask
  // edges of the clock outputs over sixteen base ticks
  task automatic t_clocks();
    int n_base = 0, n_half = 0, n_ph1 = 0, n_ph2 = 0, n_fetch = 0, n_both = 0;
    logic [4:0] last;
    last = {clk_base, clk_half, clk_ph1, clk_ph2, cpu_fetch};
    repeat (16 * `PMD_BASE_DIV) begin
      tick();
      n_base += int'(clk_base !== last[4]);
      n_half += int'(clk_half !== last[3]);
      n_ph1 += int'(clk_ph1 !== last[2]);
      n_ph2 += int'(clk_ph2 !== last[1]);
      n_fetch += int'(cpu_fetch !== last[0]);
      n_both += int'(clk_ph1 === 1'b1 && clk_ph2 === 1'b1);
      last = {clk_base, clk_half, clk_ph1, clk_ph2, cpu_fetch};
    end
    chk("base_edges", 16'(n_base), 16'h0010);
    chk("half_edges", 16'(n_half), 16'h0008);
    chk("ph1_edges", 16'(n_ph1), 16'h0004);
    chk("ph2_edges", 16'(n_ph2), 16'h0004);
    chk("ph_overlap", 16'(n_both), 16'h0000);
    chk("fetch_swaps", 16'(n_fetch), 16'h0002);
  endtask
  initial begin
    int n;
    repeat (12) tick();
    rst = 0;
    for (n = 0; n < 999 && cpu_reset_n !== 1'b1; n++) tick();
    chk("reset_hold", 16'(n > 398 && n < 403), 16'h0001);
    t_clocks();
    t_rom();
    t_ram();
    t_inputs();
    t_adapter();
    test_done();
  end
endmodule
